// ==== design/amips_defines.svh ====
// Overview of operation
// - Address bit one pin carries address bit one, or ALE during NAND access.
// - In 16-bit mode bank-one pin drives the lowest address bit.
// - In 8-bit mode bank-one pin drives the second lowest address bit.
// - In 8-bit mode bank-zero pin drives the lowest address bit.
// - Bank-zero pin may carry address bit fourteen for 16-bit memories.
// - Bank-one and address-zero pins switch together to I/O lines 55 and 56.
// - Data pins fifteen to eight switch as one group to I/O lines.
// - Four strap bits sampled at reset set the select field defaults.
// - Bank-zero field: bank, address fourteen, I/O 54, reserved; strap bits two-one.
// - Strap bit zero: 0 gives address pins, 1 gives I/O 67 to 55.
`ifndef AMIPS_DEFINES_SVH
`define AMIPS_DEFINES_SVH

// Strap bit positions.
`define AMIPS_STRAP_WIDE_BIT 0
`define AMIPS_STRAP_BA0_LO   1
`define AMIPS_STRAP_BA0_HI   2
`define AMIPS_STRAP_DATA_BIT 3

// Shared pin vector layout, index equals I/O line number minus the base.
`define AMIPS_GIO_BASE       46
`define AMIPS_NPIN           22
`define AMIPS_IDX_DATA_LO    0
`define AMIPS_NDATA          8
`define AMIPS_IDX_BA0        8
`define AMIPS_IDX_BA1        9
`define AMIPS_IDX_A0         10
`define AMIPS_IDX_MID_LO     11
`define AMIPS_NMID           11

// Reset levels of the shared pins.
`define AMIPS_RST_OUT        22'h000300
`define AMIPS_RST_OE_N       22'h0000FF

`endif

// ==== design/amips_pin_cell.sv ====
`default_nettype none
module amips_pin_cell #(
  parameter logic RST_OUT  = 1'b0,
  parameter logic RST_OE_N = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // Selection
  input  wire logic use_gio,
  // Memory interface side
  input  wire logic func_out,
  input  wire logic func_oe_n,
  output logic      func_in,
  // General I/O side
  input  wire logic gio_out,
  input  wire logic gio_oe_n,
  output logic      gio_in,
  // Pin
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_n
);

  logic nxt_out;
  logic nxt_oe_n;
  logic nxt_func_in;
  logic nxt_gio_in;
  logic out_ff;
  logic oe_n_ff;
  logic func_in_ff;
  logic gio_in_ff;

  // The owner not selected sees zero, so it never reads the other's traffic.
  always_comb begin
    if (srst) begin
      nxt_out     = RST_OUT;
      nxt_oe_n    = RST_OE_N;
      nxt_func_in = 1'b0;
      nxt_gio_in  = 1'b0;
    end else begin
      nxt_out     = use_gio ? gio_out : func_out;
      nxt_oe_n    = use_gio ? gio_oe_n : func_oe_n;
      nxt_func_in = ~use_gio & pin_in;
      nxt_gio_in  = use_gio & pin_in;
    end
  end

  always_ff @(posedge clock) begin
    out_ff     <= nxt_out;
    oe_n_ff    <= nxt_oe_n;
    func_in_ff <= nxt_func_in;
    gio_in_ff  <= nxt_gio_in;
  end

  assign pin_out  = out_ff;
  assign pin_oe_n = oe_n_ff;
  assign func_in  = func_in_ff;
  assign gio_in   = gio_in_ff;

endmodule
`default_nettype wire

// ==== design/amips_pkg.sv ====
`default_nettype none
package amips_pkg;

  typedef enum logic [1:0] {
    AMIPS_BA0_BANK,
    AMIPS_BA0_A14,
    AMIPS_BA0_GIO,
    AMIPS_BA0_RSVD
  } amips_ba0_e;

  typedef struct packed {
    logic       upper_data_pin_select_field;
    amips_ba0_e ba0_pin_select_field;
    logic       low_addr_pin_select_field;
    logic       mid_addr_pin_select_field;
  } amips_sel_s;

  typedef struct packed {
    logic        bus16;
    logic        nand_sel;
    logic        ale;
    logic        a1;
    logic        a0;
    logic        a14;
    logic [1:0]  elem_lo;
    logic [10:0] mid_addr;
    logic [7:0]  data_hi;
    logic        data_oe;
  } amips_mif_s;

endpackage
`default_nettype wire

// ==== design/amips_top.sv ====
`include "amips_defines.svh"
`default_nettype none
module amips_top (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 srst,
  // Configuration straps
  input  wire logic [3:0]           mem_if_config_straps,
  // Pin select register
  input  wire logic                 sel_wr_en,
  input  wire amips_pkg::amips_sel_s sel_wr_data,
  output var amips_pkg::amips_sel_s mem_pin_select_reg,
  // Memory interface side
  input  wire amips_pkg::amips_mif_s mif_bus,
  output logic [7:0]                mif_data_hi_in,
  // General I/O lines 46 to 67
  input  wire logic [21:0]          gio_out,
  input  wire logic [21:0]          gio_oe_n,
  output logic [21:0]               general_io_line_in,
  // Address bit one pin
  input  wire logic                 ext_addr_bit1_pin_in,
  output logic                      ext_addr_bit1_pin_out,
  output logic                      ext_addr_bit1_pin_oe_n,
  // Address bit zero pin
  input  wire logic                 ext_addr_bit0_pin_in,
  output logic                      ext_addr_bit0_pin_out,
  output logic                      ext_addr_bit0_pin_oe_n,
  // Address bits thirteen to three
  input  wire logic [10:0]          ext_addr_mid_pin_in,
  output logic [10:0]               ext_addr_mid_pin_out,
  output logic [10:0]               ext_addr_mid_pin_oe_n,
  // Bank address pins
  input  wire logic                 bank_addr_one_pin_in,
  output logic                      bank_addr_one_pin_out,
  output logic                      bank_addr_one_pin_oe_n,
  input  wire logic                 bank_addr_zero_pin_in,
  output logic                      bank_addr_zero_pin_out,
  output logic                      bank_addr_zero_pin_oe_n,
  // Data bits fifteen to eight
  input  wire logic [7:0]           ext_data_top_bit_in,
  output logic [7:0]                ext_data_top_bit_out,
  output logic [7:0]                ext_data_top_bit_oe_n
);
  import amips_pkg::*;

  amips_sel_s  sel_ff;
  amips_sel_s  nxt_sel_ff;
  logic [21:0] use_gio;
  logic [21:0] func_out;
  logic [21:0] func_oe_n;
  logic [21:0] func_in;
  logic [21:0] pin_in;
  logic [21:0] pin_out;
  logic [21:0] pin_oe_n;
  logic        a1_func;

  // Straps are caught on every reset cycle, so the last value before release
  // becomes the default; software may overwrite it afterwards.
  always_comb begin
    nxt_sel_ff = sel_ff;
    if (srst) begin
      nxt_sel_ff.mid_addr_pin_select_field =
        mem_if_config_straps[`AMIPS_STRAP_WIDE_BIT];
      nxt_sel_ff.low_addr_pin_select_field =
        mem_if_config_straps[`AMIPS_STRAP_WIDE_BIT];
      nxt_sel_ff.ba0_pin_select_field = amips_ba0_e'(
        mem_if_config_straps[`AMIPS_STRAP_BA0_HI:`AMIPS_STRAP_BA0_LO]);
      nxt_sel_ff.upper_data_pin_select_field =
        mem_if_config_straps[`AMIPS_STRAP_DATA_BIT];
    end else if (sel_wr_en) begin
      nxt_sel_ff = sel_wr_data;
    end
  end

  always_ff @(posedge clock) begin
    sel_ff <= nxt_sel_ff;
  end

  assign mem_pin_select_reg = sel_ff;

  always_comb begin
    func_out  = '0;
    func_oe_n = '1;
    use_gio   = '0;
    for (int i = 0; i < `AMIPS_NDATA; i++) begin
      func_out[`AMIPS_IDX_DATA_LO + i]  = mif_bus.data_hi[i];
      func_oe_n[`AMIPS_IDX_DATA_LO + i] = ~(mif_bus.bus16 & mif_bus.data_oe);
      use_gio[`AMIPS_IDX_DATA_LO + i]   = sel_ff.upper_data_pin_select_field;
    end
    for (int j = 0; j < `AMIPS_NMID; j++) begin
      func_out[`AMIPS_IDX_MID_LO + j]  = mif_bus.mid_addr[j];
      func_oe_n[`AMIPS_IDX_MID_LO + j] = 1'b0;
      use_gio[`AMIPS_IDX_MID_LO + j]   = sel_ff.mid_addr_pin_select_field;
    end
    use_gio[`AMIPS_IDX_A0]    = sel_ff.low_addr_pin_select_field;
    use_gio[`AMIPS_IDX_BA1]   = sel_ff.low_addr_pin_select_field;
    func_out[`AMIPS_IDX_A0]   = mif_bus.a0;
    func_oe_n[`AMIPS_IDX_A0]  = 1'b0;
    func_oe_n[`AMIPS_IDX_BA1] = 1'b0;
    func_out[`AMIPS_IDX_BA1] = mif_bus.bus16 ? mif_bus.elem_lo[0]
                                             : mif_bus.elem_lo[1];
    // In 16-bit bank mode the bank-zero pin has no address role and idles low.
    unique case (sel_ff.ba0_pin_select_field)
      AMIPS_BA0_BANK: begin
        func_out[`AMIPS_IDX_BA0]  = ~mif_bus.bus16 & mif_bus.elem_lo[0];
        func_oe_n[`AMIPS_IDX_BA0] = 1'b0;
      end
      AMIPS_BA0_A14: begin
        func_out[`AMIPS_IDX_BA0]  = mif_bus.bus16 ? mif_bus.a14
                                                  : mif_bus.elem_lo[0];
        func_oe_n[`AMIPS_IDX_BA0] = 1'b0;
      end
      AMIPS_BA0_GIO: begin
        use_gio[`AMIPS_IDX_BA0] = 1'b1;
      end
      AMIPS_BA0_RSVD: begin
        // The reserved code floats the pin rather than guess a function.
        func_oe_n[`AMIPS_IDX_BA0] = 1'b1;
      end
    endcase
  end

  assign a1_func = mif_bus.nand_sel ? mif_bus.ale : mif_bus.a1;

  assign pin_in = {ext_addr_mid_pin_in, ext_addr_bit0_pin_in,
                   bank_addr_one_pin_in, bank_addr_zero_pin_in,
                   ext_data_top_bit_in};

  genvar g;
  generate
    for (g = 0; g < `AMIPS_NPIN; g++) begin : g_pin
      amips_pin_cell #(
        .RST_OUT  (1'(`AMIPS_RST_OUT >> g)),
        .RST_OE_N (1'(`AMIPS_RST_OE_N >> g))
      ) u_cell (
        .clock     (clock),
        .srst      (srst),
        .use_gio   (use_gio[g]),
        .func_out  (func_out[g]),
        .func_oe_n (func_oe_n[g]),
        .func_in   (func_in[g]),
        .gio_out   (gio_out[g]),
        .gio_oe_n  (gio_oe_n[g]),
        .gio_in    (general_io_line_in[g]),
        .pin_in    (pin_in[g]),
        .pin_out   (pin_out[g]),
        .pin_oe_n  (pin_oe_n[g])
      );
    end
  endgenerate

  amips_pin_cell #(
    .RST_OUT  (1'b0),
    .RST_OE_N (1'b0)
  ) u_a1_cell (
    .clock     (clock),
    .srst      (srst),
    .use_gio   (1'b0),
    .func_out  (a1_func),
    .func_oe_n (1'b0),
    .func_in   (),
    .gio_out   (1'b0),
    .gio_oe_n  (1'b1),
    .gio_in    (),
    .pin_in    (ext_addr_bit1_pin_in),
    .pin_out   (ext_addr_bit1_pin_out),
    .pin_oe_n  (ext_addr_bit1_pin_oe_n)
  );

  assign mif_data_hi_in          = func_in[7:0];
  assign ext_data_top_bit_out    = pin_out[7:0];
  assign ext_data_top_bit_oe_n   = pin_oe_n[7:0];
  assign bank_addr_zero_pin_out  = pin_out[`AMIPS_IDX_BA0];
  assign bank_addr_zero_pin_oe_n = pin_oe_n[`AMIPS_IDX_BA0];
  assign bank_addr_one_pin_out   = pin_out[`AMIPS_IDX_BA1];
  assign bank_addr_one_pin_oe_n  = pin_oe_n[`AMIPS_IDX_BA1];
  assign ext_addr_bit0_pin_out   = pin_out[`AMIPS_IDX_A0];
  assign ext_addr_bit0_pin_oe_n  = pin_oe_n[`AMIPS_IDX_A0];
  assign ext_addr_mid_pin_out    = pin_out[21:11];
  assign ext_addr_mid_pin_oe_n   = pin_oe_n[21:11];

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence run_s;
    !$past(srst);
  endsequence

  sequence strap_rel_s;
    $past(srst) ##0 !srst;
  endsequence

  a1_ale_a: assert property (
    run_s ##0 $past(mif_bus.nand_sel) |->
      ext_addr_bit1_pin_out == $past(mif_bus.ale) && !ext_addr_bit1_pin_oe_n)
    else $error("address one pin does not follow ALE");
  a1_addr_a: assert property (
    run_s ##0 !$past(mif_bus.nand_sel) |->
      ext_addr_bit1_pin_out == $past(mif_bus.a1))
    else $error("address one pin does not follow address");
  ba1_wide_a: assert property (
    run_s ##0 $past(!sel_ff.low_addr_pin_select_field && mif_bus.bus16) |->
      bank_addr_one_pin_out == $past(mif_bus.elem_lo[0]))
    else $error("bank one pin wrong in 16-bit mode");
  ba1_narrow_a: assert property (
    run_s ##0 $past(!sel_ff.low_addr_pin_select_field && !mif_bus.bus16) |->
      bank_addr_one_pin_out == $past(mif_bus.elem_lo[1]))
    else $error("bank one pin wrong in 8-bit mode");
  ba0_narrow_a: assert property (
    run_s ##0 $past(sel_ff.ba0_pin_select_field == AMIPS_BA0_BANK &&
                    !mif_bus.bus16) |->
      bank_addr_zero_pin_out == $past(mif_bus.elem_lo[0]))
    else $error("bank zero pin wrong in 8-bit mode");
  ba0_a14_a: assert property (
    run_s ##0 $past(sel_ff.ba0_pin_select_field == AMIPS_BA0_A14 &&
                    mif_bus.bus16) |->
      bank_addr_zero_pin_out == $past(mif_bus.a14) &&
      !bank_addr_zero_pin_oe_n)
    else $error("bank zero pin not address fourteen");
  low_gio_a: assert property (
    run_s ##0 $past(sel_ff.low_addr_pin_select_field) |->
      bank_addr_one_pin_out == $past(gio_out[`AMIPS_IDX_BA1]) &&
      ext_addr_bit0_pin_oe_n == $past(gio_oe_n[`AMIPS_IDX_A0]))
    else $error("low pins not handed to I/O lines");
  data_gio_a: assert property (
    run_s ##0 $past(sel_ff.upper_data_pin_select_field) |->
      ext_data_top_bit_out == $past(gio_out[7:0]) &&
      ext_data_top_bit_oe_n == $past(gio_oe_n[7:0]))
    else $error("data group not handed to I/O lines");
  strap_load_a: assert property (@(posedge clock) disable iff (1'b0)
    strap_rel_s |->
      sel_ff.ba0_pin_select_field == $past(mem_if_config_straps[2:1]) &&
      sel_ff.mid_addr_pin_select_field == $past(mem_if_config_straps[0]) &&
      sel_ff.low_addr_pin_select_field == $past(mem_if_config_straps[0]) &&
      sel_ff.upper_data_pin_select_field == $past(mem_if_config_straps[3]))
    else $error("select defaults not taken from straps");
  ba0_rsvd_a: assert property (
    run_s ##0 $past(sel_ff.ba0_pin_select_field == AMIPS_BA0_RSVD) |->
      bank_addr_zero_pin_oe_n)
    else $error("reserved bank zero code drives the pin");
  mid_gio_a: assert property (
    run_s ##0 $past(sel_ff.mid_addr_pin_select_field) |->
      ext_addr_mid_pin_out == $past(gio_out[21:11]))
    else $error("middle address pins not on I/O lines");
  reset_lvl_a: assert property (@(posedge clock) disable iff (1'b0)
    $past(srst) |-> !ext_addr_bit1_pin_out && bank_addr_one_pin_out &&
      bank_addr_zero_pin_out && ext_data_top_bit_oe_n == 8'hFF &&
      ext_addr_mid_pin_out == 11'h000)
    else $error("pin levels wrong during reset");

endmodule
`default_nettype wire

// ==== verif/amips_mem_model.sv ====
`default_nettype none
module amips_mem_model (
  // Clock
  input  wire logic        clock,
  // Device pin drive, shared layout with address bit one on top
  input  wire logic [22:0] dev_out,
  input  wire logic [22:0] dev_oe_n,
  // Resolved pin levels
  output logic [22:0]      level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [22:0] ext_ff;

  // Released pins show a new pattern every cycle, so a stale value or a
  // simulator's choice for an undriven line never passes for a match.
  always @(posedge clock) begin
    ext_ff <= 23'($urandom);
  end

  assign level = (dev_out & ~dev_oe_n) | (ext_ff & dev_oe_n);
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`default_nettype none
module testbench;
  import amips_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock       = 1'b0;
  logic        srst        = 1'b1;
  logic        sel_wr_en   = 1'b0;
  logic [3:0]  straps      = 4'h0;
  amips_sel_s  sel_wr_data = '0;
  amips_sel_s  sel_reg;
  amips_mif_s  mif_bus     = '0;
  logic [21:0] gio_out     = '0;
  logic [21:0] gio_oe_n    = '1;
  logic [21:0] gio_in;
  logic [7:0]  dat_in;
  wire  [22:0] p_out;
  wire  [22:0] p_oe_n;
  wire  [22:0] lvl;
  int          num_errors  = 0;
  int          tests_run   = 0;
  int          cyc         = 0;
  amips_sel_s  esel;
  logic [22:0] eo;
  logic [22:0] ee;
  logic [21:0] egio;
  logic [7:0]  edat;
  logic        armed       = 1'b0;

  always #25 clock = ~clock;

  amips_top u_amips_top (
    .clock(clock), .srst(srst), .mem_if_config_straps(straps),
    .sel_wr_en(sel_wr_en), .sel_wr_data(sel_wr_data),
    .mem_pin_select_reg(sel_reg), .mif_bus(mif_bus),
    .mif_data_hi_in(dat_in), .gio_out(gio_out), .gio_oe_n(gio_oe_n),
    .general_io_line_in(gio_in),
    .ext_addr_bit1_pin_in(lvl[22]), .ext_addr_bit1_pin_out(p_out[22]),
    .ext_addr_bit1_pin_oe_n(p_oe_n[22]),
    .ext_addr_bit0_pin_in(lvl[10]), .ext_addr_bit0_pin_out(p_out[10]),
    .ext_addr_bit0_pin_oe_n(p_oe_n[10]),
    .ext_addr_mid_pin_in(lvl[21:11]), .ext_addr_mid_pin_out(p_out[21:11]),
    .ext_addr_mid_pin_oe_n(p_oe_n[21:11]),
    .bank_addr_one_pin_in(lvl[9]), .bank_addr_one_pin_out(p_out[9]),
    .bank_addr_one_pin_oe_n(p_oe_n[9]),
    .bank_addr_zero_pin_in(lvl[8]), .bank_addr_zero_pin_out(p_out[8]),
    .bank_addr_zero_pin_oe_n(p_oe_n[8]),
    .ext_data_top_bit_in(lvl[7:0]), .ext_data_top_bit_out(p_out[7:0]),
    .ext_data_top_bit_oe_n(p_oe_n[7:0])
  );

  amips_mem_model u_amips_mem_model (
    .clock(clock), .dev_out(p_out), .dev_oe_n(p_oe_n), .level(lvl)
  );

  function automatic logic [21:0] owns(amips_sel_s s);
    return {{11{s.mid_addr_pin_select_field}},
            {2{s.low_addr_pin_select_field}},
            s.ba0_pin_select_field == AMIPS_BA0_GIO,
            {8{s.upper_data_pin_select_field}}};
  endfunction

  function automatic logic [45:0] pins(amips_sel_s s, amips_mif_s m,
                                       logic [21:0] go, logic [21:0] ge);
    logic [22:0] o;
    logic [22:0] e;
    logic [21:0] w;
    w = owns(s);
    o = {m.nand_sel ? m.ale : m.a1, m.mid_addr, m.a0,
         m.bus16 ? m.elem_lo[0] : m.elem_lo[1], m.elem_lo[0], m.data_hi};
    if (m.bus16) begin
      o[8] = (s.ba0_pin_select_field == AMIPS_BA0_A14) & m.a14;
    end
    e = {15'h0000, {8{~(m.bus16 & m.data_oe)}}};
    e[8] = (s.ba0_pin_select_field == AMIPS_BA0_RSVD);
    o[21:0] = (o[21:0] & ~w) | (go & w);
    e[21:0] = (e[21:0] & ~w) | (ge & w);
    return {o, e};
  endfunction

  // Reference model: reads the values standing before each edge.
  always @(posedge clock) begin
    armed <= 1'b1;
    if (srst) begin
      esel <= {straps[3], straps[2:1], straps[0], straps[0]};
      {eo, ee} <= {23'h000300, 23'h0000FF};
      egio <= '0;
      edat <= '0;
    end else begin
      {eo, ee} <= pins(esel, mif_bus, gio_out, gio_oe_n);
      egio <= lvl[21:0] & owns(esel);
      edat <= esel.upper_data_pin_select_field ? 8'h00 : lvl[7:0];
      if (sel_wr_en) begin
        esel <= sel_wr_data;
      end
    end
  end

  task automatic chk(input logic [22:0] g, input logic [22:0] e,
                     input string m);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t %s mismatch", $time, m);
    end
  endtask

  // Output levels are compared only where the pin is expected to drive.
  task automatic grp(input logic [22:0] m, input string s);
    chk(p_oe_n & m, ee & m, s);
    chk(p_out & m & ~ee, eo & m & ~ee, s);
  endtask

  always @(negedge clock) begin
    if (armed) begin
      grp(23'h400000, "addr bit one pin");
      grp(23'h000200, "bank one pin");
      grp(23'h000100, "bank zero pin");
      grp(23'h000400, "addr bit zero pin");
      grp(23'h0000FF, "upper data pins");
      grp(23'h3FF800, "mid addr pins");
      chk(23'(sel_reg), 23'(esel), "select register");
      chk(23'(gio_in), 23'(egio), "io line inputs");
      chk(23'(dat_in), 23'(edat), "data inputs");
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Random traffic with a write now and then; short resets recur so that
  // strap sampling and writes refused during reset are both exercised.
  // Drawn in the seeded process, so the seed governs every stimulus value except the memory model's released-pin levels.
  initial begin
    void'($urandom(32'h8d10867f));
    repeat (3000) begin
      @(posedge clock);
      cyc <= cyc + 1;
      srst <= (cyc < 7) || (cyc % 500 > 496);
      straps <= 4'($urandom);
      sel_wr_en <= ($urandom % 6) == 0;
      sel_wr_data <= 5'($urandom);
      mif_bus <= 28'($urandom);
      gio_out <= 22'($urandom);
      gio_oe_n <= 22'($urandom);
    end
    test_done;
  end

  initial begin
    #(4000 * 50);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done;
  end
endmodule
`default_nettype wire
